// >>> sim/adc_sequencer_control_asserts.sv
// port checker for the converter sequencer.
// assumes one clock, sync active-low reset; bound below.
`timescale 1ns/100ps
module adc_sequencer_control_asserts
  import adc_seq_pkg::*;
(
  // watched ports
  input  wire logic                      clk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      standby_i,
  input  wire adc_seq_pkg::bus_req_t     bus_req_i,
  input  wire logic               [31:0] bus_rdata_o,
  input  wire logic                      bus_ack_o,
  input  wire logic                      conv_end_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic rd_c;
  logic wr_c;
  logic st_wr_c;

  // request decode
  assign rd_c    = bus_req_i.sel && !bus_req_i.wr;
  assign wr_c    = bus_req_i.sel && bus_req_i.wr;
  assign st_wr_c = wr_c && bus_req_i.addr == CTRL_STATUS_ADDR;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  write_ack_a: assert property (wr_c |=> bus_ack_o)
    else $error("write not acked next cycle");
  read_ack_a: assert property (rd_c |-> ##2 bus_ack_o)
    else $error("read not acked two cycles on");
  ack_cause_a: assert property (
    bus_ack_o |-> $past(wr_c) || $past(rd_c, 2))
    else $error("ack without request");
  ctrl_reserved_a: assert property (
    rd_c && bus_req_i.addr == TRIG_SCAN_ADDR
    |-> ##2 bus_rdata_o[4:0] == 5'h07)
    else $error("reserved control bits wrong");
  standby_init_a: assert property (
    rd_c && standby_i && bus_req_i.addr == TRIG_SCAN_ADDR
    |-> ##2 bus_rdata_o[7:0] == 8'h07)
    else $error("control not at init in standby");
  long_pad_a: assert property (
    rd_c && bus_req_i.size == SIZE_LONG && bus_req_i.addr < 5'h08
    |-> ##2 bus_rdata_o[13:8] == 6'h00)
    else $error("long read low lane not ten-bit");
  irq_flag_a: assert property (
    rd_c && bus_req_i.addr == CTRL_STATUS_ADDR
    |-> ##2 conv_end_irq_o == (bus_rdata_o[7] && bus_rdata_o[6]))
    else $error("irq disagrees with flag and enable");
  irq_clear_a: assert property (
    $fell(conv_end_irq_o) |-> $past(st_wr_c, 2))
    else $error("irq dropped without status write");
  unmapped_zero_a: assert property (
    rd_c && bus_req_i.addr inside {[5'h08:5'h0F]}
    |-> ##2 bus_rdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property (disable iff (1'b0)
    !resetn_i |=> !bus_ack_o && !conv_end_irq_o)
    else $error("outputs active in reset");

  // main scenarios
  irq_seen_c: cover property ($rose(conv_end_irq_o));
  long_rd_c: cover property (rd_c && bus_req_i.size == SIZE_LONG);
  standby_c: cover property (rd_c && standby_i);
endmodule : adc_sequencer_control_asserts

bind adc_sequencer_control adc_sequencer_control_asserts
  adc_sequencer_control_asserts_i (
  .clk_i(clk_i), .resetn_i(resetn_i), .standby_i(standby_i),
  .bus_req_i(bus_req_i), .bus_rdata_o(bus_rdata_o),
  .bus_ack_o(bus_ack_o), .conv_end_irq_o(conv_end_irq_o));

// >>> sim/adc_sequencer_control_test.sv
// self-checking bench for the converter sequencer.
// assumes the bus master model and the bound port checker.
`timescale 1ns/100ps
module adc_sequencer_control_test;
  import adc_seq_pkg::*;
  typedef struct {logic [4:0] a; logic [7:0] wd; logic [7:0] ex;} row_t;
  logic        clk_i, resetn_i, standby_i, trig_i, ack, irq;
  logic [31:0] rdata, rd;
  bus_req_t    req;
  analog_vec_t ana;
  int          mismatches, n_checks, e;
  row_t rows[6] = '{'{5'h12, 8'hC0, 8'hC7}, '{5'h12, 8'h40, 8'h47},
    '{5'h12, 8'hA0, 8'hA7}, '{5'h10, 8'h4B, 8'h4B},
    '{5'h10, 8'h00, 8'h00}, '{5'h12, 8'h00, 8'h07}};

  adc_sequencer_control adc_sequencer_control_i (.clk_i(clk_i),
    .resetn_i(resetn_i), .standby_i(standby_i), .bus_req_i(req),
    .bus_rdata_o(rdata), .bus_ack_o(ack), .ext_trigger_pin_i(trig_i),
    .analog_in_i(ana), .conv_end_irq_o(irq));
  bus_master_model bus_master_model_i (.clk_i(clk_i), .bus_req_o(req),
    .bus_rdata_i(rdata), .bus_ack_i(ack));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] ex);
    n_checks++;
    if (got !== ex) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, ex);
    end
  endtask : chk
  task automatic wb(input logic [4:0] a, input logic [7:0] d);
    bus_master_model_i.xfer(1'b1, SIZE_BYTE, a, d, rd);
  endtask : wb
  task automatic rb(input logic [4:0] a, input acc_size_t s = SIZE_BYTE);
    bus_master_model_i.xfer(1'b0, s, a, 8'h00, rd);
  endtask : rb
  task automatic wait_irq(input int n);
    int i;
    for (i = 0; i < n && irq !== 1'b1; i++) @(posedge clk_i);
    chk({7'h00, irq}, 8'h01);
  endtask : wait_irq
  task automatic final_report();
    $display("mismatches %0d n_checks %0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    #1_200_000;
    mismatches++;
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    n_checks = 0;
    resetn_i = 1'b0;
    standby_i = 1'b0;
    trig_i = 1'b1;
    ana = '{10'h0F0, 10'h16B, 10'h2A5, 10'h3C5};
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    rb(TRIG_SCAN_ADDR);
    chk(rd[7:0], 8'h07);
    rb(CTRL_STATUS_ADDR);
    chk(rd[7:0], 8'h00);
    foreach (rows[i]) begin
      wb(rows[i].a, rows[i].wd);
      rb(rows[i].a);
      chk(rd[7:0], rows[i].ex);
    end
    // single conversion, channel 1, fast, irq enabled
    wb(CTRL_STATUS_ADDR, 8'h69);
    rb(CTRL_STATUS_ADDR);
    chk(rd[7:0], 8'h69);
    wait_irq(600);
    rb(CTRL_STATUS_ADDR);
    chk(rd[7:0], 8'hC9);
    rb(5'h02);
    chk(rd[15:8], ana.ch1[9:2]);
    rb(5'h03);
    chk(rd[15:8], {ana.ch1[1:0], 6'h00});
    rb(5'h02, SIZE_WORD);
    chk(rd[15:8], ana.ch1[9:2]);
    rb(5'h02, SIZE_LONG);
    chk(rd[31:24], ana.ch1[9:2]);
    chk(rd[15:8], {ana.ch1[1:0], 6'h00});
    wb(CTRL_STATUS_ADDR, 8'h48);
    chk({7'h00, irq}, 8'h00);
    // trigger enable codes; only 11 starts
    for (e = 0; e < 4; e++) begin
      wb(TRIG_SCAN_ADDR, 8'(e << 6));
      trig_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      trig_i <= 1'b1;
      rb(CTRL_STATUS_ADDR);
      chk(rd[7:0], e == 3 ? 8'h68 : 8'h48);
    end
    wait_irq(600);
    rb(5'h00);
    chk(rd[15:8], ana.ch0[9:2]);
    rb(CTRL_STATUS_ADDR);
    wb(CTRL_STATUS_ADDR, 8'h48);
    wb(TRIG_SCAN_ADDR, 8'h00);
    // multi, channels 0 to 2; start set with the mode
    ana <= '{10'h0AB, 10'h333, 10'h222, 10'h111};
    wb(CTRL_STATUS_ADDR, 8'h72);
    wait_irq(1700);
    wb(CTRL_STATUS_ADDR, 8'h52);
    chk({7'h00, irq}, 8'h01);
    rb(CTRL_STATUS_ADDR);
    chk(rd[7:0], 8'hD2);
    for (e = 0; e < 4; e++) begin
      rb(5'(2 * e));
      chk(rd[15:8], e < 3 ? ana[e*10+2 +: 8] : 8'h00);
    end
    wb(CTRL_STATUS_ADDR, 8'h52);
    chk({7'h00, irq}, 8'h00);
    // scan: flag per pass, start stays until halted
    wb(TRIG_SCAN_ADDR, 8'h20);
    wb(CTRL_STATUS_ADDR, 8'h7A);
    wait_irq(1200);
    rb(CTRL_STATUS_ADDR);
    chk(rd[7:0], 8'hFA);
    wb(CTRL_STATUS_ADDR, 8'h58);
    ana <= '{10'h0AB, 10'h333, 10'h222, 10'h3FF};
    wb(CTRL_STATUS_ADDR, 8'h78);
    wait_irq(600);
    rb(5'h00);
    chk(rd[15:8], 8'hFF);
    wb(CTRL_STATUS_ADDR, 8'h58);
    // standby forces the control register back
    wb(TRIG_SCAN_ADDR, 8'hC0);
    standby_i <= 1'b1;
    rb(TRIG_SCAN_ADDR);
    chk(rd[7:0], 8'h07);
    standby_i <= 1'b0;
    // unmapped read and ignored result write
    rb(5'h08);
    chk(rd[7:0], 8'h00);
    wb(5'h00, 8'h12);
    rb(5'h00);
    chk(rd[15:8], 8'hFF);
    final_report();
  end
endmodule : adc_sequencer_control_test

// >>> sim/bus_master_model.sv
// bus master model: one-cycle strobe, fields held until the answer.
// assumes it shares clk_i with the sequencer.
`timescale 1ns/100ps
module bus_master_model
  import adc_seq_pkg::*;
(
  // clock
  input  wire logic               clk_i,
  // peripheral bus
  output adc_seq_pkg::bus_req_t   bus_req_o,
  input  wire logic        [31:0] bus_rdata_i,
  input  wire logic               bus_ack_i
);
  initial bus_req_o = '0;

  // one transfer; released fields are scrambled, not left stale
  task automatic xfer(input logic wr, input acc_size_t sz,
                      input logic [4:0] a, input logic [7:0] wd,
                      output logic [31:0] rd);
    int i;
    @(posedge clk_i) bus_req_o <= '{1'b1, wr, sz, a, {24'h00_0000, wd}};
    @(posedge clk_i) bus_req_o.sel <= 1'b0;
    #1;
    for (i = 0; i < 8; i++) begin
      if (bus_ack_i === 1'b1) break;
      @(posedge clk_i) #1;
    end
    rd = bus_rdata_i;
    @(posedge clk_i) bus_req_o <= {1'b0, ~bus_req_o[39:0]};
    #1; // let outputs launched on this edge settle before callers look
  endtask : xfer
endmodule : bus_master_model

// >>> verilog/adc_seq_pkg.sv
// package of the converter sequencer: register map, field positions,
// reset values, conversion timing and the carrier types.
// assumes one peripheral clock, one state per clock cycle.
package adc_seq_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the peripheral bus)
  // ----------------------------------------------------------------
  localparam int          ADDR_W           = 5;
  localparam logic [4:0]  RESULT_BASE      = 5'h00; // a..d, high/low pairs
  localparam logic [4:0]  CTRL_STATUS_ADDR = 5'h10; // conv_control_status
  localparam logic [4:0]  TRIG_SCAN_ADDR   = 5'h12; // trigger_scan_control

  // ----------------------------------------------------------------
  // conv_control_status fields
  // ----------------------------------------------------------------
  localparam int         END_FLAG_BIT  = 7;
  localparam int         IRQ_EN_BIT    = 6;
  localparam int         START_BIT     = 5;
  localparam int         MULTI_BIT     = 4;
  localparam int         TIME_SEL_BIT  = 3;
  localparam int         CHAN_MSB      = 2;
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;

  // ----------------------------------------------------------------
  // trigger_scan_control fields
  // ----------------------------------------------------------------
  localparam int         TRIG_HI_BIT   = 7;
  localparam int         TRIG_LO_BIT   = 6;
  localparam int         SCAN_BIT      = 5;
  localparam logic [7:0] TRIG_SCAN_RESET = 8'h07;
  localparam logic [7:0] TRIG_SCAN_WMASK = 8'hE0; // writable bits
  localparam logic [7:0] TRIG_SCAN_ONES  = 8'h07; // read-only ones

  // ----------------------------------------------------------------
  // conversion figures, in states (one state per clock)
  // ----------------------------------------------------------------
  localparam int RES_BITS          = 10;
  localparam int CNT_W             = 10;
  localparam int STATES_PER_CYCLE  = 1;
  localparam int FIRST_STATES_SLOW = 536;
  localparam int FIRST_STATES_FAST = 266;
  localparam int NEXT_STATES_SLOW  = 512;
  localparam int NEXT_STATES_FAST  = 256;
  localparam logic [CNT_W-1:0] FIRST_CYC_SLOW =
    CNT_W'(FIRST_STATES_SLOW * STATES_PER_CYCLE);
  localparam logic [CNT_W-1:0] FIRST_CYC_FAST =
    CNT_W'(FIRST_STATES_FAST * STATES_PER_CYCLE);
  localparam logic [CNT_W-1:0] NEXT_CYC_SLOW =
    CNT_W'(NEXT_STATES_SLOW * STATES_PER_CYCLE);
  localparam logic [CNT_W-1:0] NEXT_CYC_FAST =
    CNT_W'(NEXT_STATES_FAST * STATES_PER_CYCLE);

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_WORD = 2'b01,
    SIZE_LONG = 2'b10
  } acc_size_t;

  typedef struct packed {
    logic              sel;   // access strobe, one cycle
    logic              wr;    // 1 write, 0 read
    acc_size_t         size;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } bus_req_t;

  typedef struct packed {
    logic [RES_BITS-1:0] ch3;
    logic [RES_BITS-1:0] ch2;
    logic [RES_BITS-1:0] ch1;
    logic [RES_BITS-1:0] ch0;
  } analog_vec_t;

endpackage : adc_seq_pkg

// >>> verilog/adc_sequencer_control.sv
// converter sequencer top: register file, result read path, trigger,
// and single / multi / scan sequencing around the conversion core.
// assumes bus master on clk_i; ext trigger and analog levels are async.
//
// Operation
// - control register resets to 0x07, also standby
// - trigger enables 00, 01, 10 ignore trigger
// - enables 11: falling trigger edge starts conversion
// - scan bit picks multi or scan mode
// - bits 4,3 read zero, write zero
// - bits 2..0 read one, write zero
// - result high byte direct, low via latch
// - high read loads latch; low read returns it
// - word read: value on 15..8 only
// - long read: high 31..24, low 15..8
// - ten-bit successive approximation result
// - single mode converts once, start self-clears
// - single end sets flag, interrupt if enabled
// - flag clears by read-one then write-zero
// - single result goes to channel's register
// - multi mode walks group from first channel
// - multi end: flag, start cleared, interrupt
// - channels 0..3 store into registers a..d
// - restart after halt begins at first channel
// - channel code selects one or group
// - scan repeats passes, flag each pass
// - trigger sets start, same as software
// - later conversions take 512 or 256 states
`timescale 1ns/100ps
module adc_sequencer_control (
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      standby_i,
  // peripheral bus
  input  wire adc_seq_pkg::bus_req_t     bus_req_i,
  output logic                    [31:0] bus_rdata_o,
  output logic                           bus_ack_o,
  // pins
  input  wire logic                      ext_trigger_pin_i,
  input  wire adc_seq_pkg::analog_vec_t  analog_in_i,
  // interrupt request
  output logic                           conv_end_irq_o
);
  import adc_seq_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_result(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:3] == RESULT_BASE[ADDR_W-1:3];
  endfunction : is_result

  function automatic logic is_low_byte(input logic [ADDR_W-1:0] a);
    return a[0];
  endfunction : is_low_byte

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_NEXT = 3'b100
  } seq_state_t;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]          trig_scan_q;
  logic                end_flag_q;
  logic                irq_en_q;
  logic                start_q;
  logic                multi_q;
  logic                time_sel_q;
  logic [2:0]          chan_q;
  logic                clr_armed_q;
  logic [2:0]          trig_sync_q;
  analog_vec_t         ana_s1_q;
  analog_vec_t         ana_s2_q;
  seq_state_t          state_q;
  logic [1:0]          cur_chan_q;
  logic                first_q;
  logic                launch_q;
  logic [7:0]          temp_q;
  logic                rd1_q;
  logic [ADDR_W-1:0]   addr1_q;
  acc_size_t           size1_q;
  logic                wr1_q;
  logic [7:0]          status_val;
  logic [7:0]          trig_val;
  logic                rd_req;
  logic                wr_req;
  logic                trig_fall;
  logic                trig_on;
  logic                scan_mode;
  logic [1:0]          last_chan;
  logic                core_done;
  logic [RES_BITS-1:0] core_result;
  logic [15:0]         rd_word;
  logic [CNT_W-1:0]    cycles;
  logic                seq_end;
  logic                pass_end;
  logic                abort;

  // ----------------------------------------------------------------
  // request decode and derived values
  // ----------------------------------------------------------------
  assign rd_req    = bus_req_i.sel & ~bus_req_i.wr;
  assign wr_req    = bus_req_i.sel & bus_req_i.wr;
  assign trig_on   = trig_scan_q[TRIG_HI_BIT] &
                     trig_scan_q[TRIG_LO_BIT];
  assign trig_fall = trig_sync_q[2] & ~trig_sync_q[1];
  assign scan_mode = multi_q & trig_scan_q[SCAN_BIT];
  assign last_chan = chan_q[1:0];
  assign trig_val  = (trig_scan_q & TRIG_SCAN_WMASK)
                     | TRIG_SCAN_ONES;
  assign status_val = {end_flag_q, irq_en_q, start_q, multi_q,
                       time_sel_q, chan_q};
  assign abort     = (state_q != ST_IDLE) & ~start_q;
  assign pass_end  = core_done & (~multi_q | cur_chan_q == last_chan);
  assign seq_end   = pass_end & ~scan_mode;

  // first conversion uses the long figure, later ones the fixed one
  always_comb begin
    if (first_q) begin
      cycles = time_sel_q ? FIRST_CYC_FAST : FIRST_CYC_SLOW;
    end else begin
      cycles = time_sel_q ? NEXT_CYC_FAST : NEXT_CYC_SLOW;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // trigger: two flops, third stage only for the edge
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      trig_sync_q <= 3'b111;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], ext_trigger_pin_i};
    end
  end

  // analog levels into the core
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ana_s1_q <= '0;
      ana_s2_q <= '0;
    end else begin
      ana_s1_q <= analog_in_i;
      ana_s2_q <= ana_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // trigger and scan control
  always_ff @(posedge clk_i) begin
    if (!resetn_i || standby_i) begin
      trig_scan_q <= TRIG_SCAN_RESET;
    end else if (wr_req && bus_req_i.addr == TRIG_SCAN_ADDR) begin
      trig_scan_q <= (bus_req_i.wdata[7:0] & TRIG_SCAN_WMASK)
                     | TRIG_SCAN_ONES;
    end
  end

  // mode, time select, channel and interrupt enable
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      irq_en_q   <= CTRL_STATUS_RESET[IRQ_EN_BIT];
      multi_q    <= CTRL_STATUS_RESET[MULTI_BIT];
      time_sel_q <= CTRL_STATUS_RESET[TIME_SEL_BIT];
      chan_q     <= CTRL_STATUS_RESET[CHAN_MSB:0];
    end else if (wr_req && bus_req_i.addr == CTRL_STATUS_ADDR) begin
      irq_en_q   <= bus_req_i.wdata[IRQ_EN_BIT];
      multi_q    <= bus_req_i.wdata[MULTI_BIT];
      time_sel_q <= bus_req_i.wdata[TIME_SEL_BIT];
      chan_q     <= bus_req_i.wdata[CHAN_MSB:0];
    end
  end

  // start bit: software, trigger, self-clear at sequence end
  always_ff @(posedge clk_i) begin
    if (!resetn_i || standby_i) begin
      start_q <= CTRL_STATUS_RESET[START_BIT];
    end else if (trig_on && trig_fall) begin
      start_q <= 1'b1;
    end else if (wr_req && bus_req_i.addr == CTRL_STATUS_ADDR) begin
      start_q <= bus_req_i.wdata[START_BIT];
    end else if (seq_end) begin
      start_q <= 1'b0;
    end
  end

  // clear arming: status read with the flag set
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      clr_armed_q <= 1'b0;
    end else if (rd_req && bus_req_i.addr == CTRL_STATUS_ADDR) begin
      clr_armed_q <= end_flag_q;
    end else if (wr_req && bus_req_i.addr == CTRL_STATUS_ADDR) begin
      clr_armed_q <= 1'b0;
    end
  end

  // end flag: setting wins over the clearing write
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      end_flag_q <= CTRL_STATUS_RESET[END_FLAG_BIT];
    end else if (pass_end && state_q == ST_CONV) begin
      end_flag_q <= 1'b1;
    end else if (wr_req && bus_req_i.addr == CTRL_STATUS_ADDR &&
                 clr_armed_q && !bus_req_i.wdata[END_FLAG_BIT]) begin
      end_flag_q <= 1'b0;
    end
  end

  // interrupt request level
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      conv_end_irq_o <= 1'b0;
    end else begin
      conv_end_irq_o <= end_flag_q & irq_en_q;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // walks channels, launches the core one cycle after deciding
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_q    <= ST_IDLE;
      cur_chan_q <= 2'b00;
      first_q    <= 1'b1;
      launch_q   <= 1'b0;
    end else begin
      launch_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          first_q <= 1'b1;
          if (start_q) begin
            // single: chosen channel; groups from channel 0
            cur_chan_q <= multi_q ? 2'b00 : chan_q[1:0];
            launch_q   <= 1'b1;
            state_q    <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (abort) begin
            state_q <= ST_IDLE;
          end else if (core_done) begin
            first_q <= 1'b0;
            state_q <= seq_end ? ST_IDLE : ST_NEXT;
            cur_chan_q <= pass_end ? 2'b00
                                   : cur_chan_q + 2'b01;
          end
        end
        ST_NEXT: begin
          if (abort) begin
            state_q <= ST_IDLE;
          end else begin
            launch_q <= 1'b1;
            state_q  <= ST_CONV;
          end
        end
      endcase
    end
  end

  // conversion core
  sar_core u_core (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .start_i  (launch_q),
    .abort_i  (abort),
    .chan_i   (cur_chan_q),
    .cycles_i (cycles),
    .analog_i (ana_s2_q),
    .done_o   (core_done),
    .result_o (core_result)
  );

  // result words, left-aligned ten bits
  result_store u_store (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .wr_en_i   (core_done & state_q == ST_CONV & ~abort),
    .wr_idx_i  (cur_chan_q),
    .wr_data_i ({core_result, 6'b00_0000}),
    .rd_idx_i  (bus_req_i.addr[2:1]),
    .rd_data_o (rd_word)
  );

  // ----------------------------------------------------------------
  // bus answer path
  // ----------------------------------------------------------------
  // first stage: hold request while the store reads
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rd1_q   <= 1'b0;
      wr1_q   <= 1'b0;
      addr1_q <= '0;
      size1_q <= SIZE_BYTE;
    end else begin
      rd1_q   <= rd_req;
      wr1_q   <= wr_req;
      addr1_q <= bus_req_i.addr;
      size1_q <= bus_req_i.size;
    end
  end

  // low byte latch, loaded by a high byte read
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      temp_q <= 8'h00;
    end else if (rd1_q && is_result(addr1_q) && !is_low_byte(addr1_q)) begin
      temp_q <= rd_word[7:0];
    end
  end

  // read data and acknowledge
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      bus_rdata_o <= 32'h0000_0000;
      bus_ack_o   <= 1'b0;
    end else begin
      bus_ack_o   <= rd1_q | wr_req;
      if (rd1_q) begin
        bus_rdata_o <= 32'h0000_0000;
        if (is_result(addr1_q)) begin
          unique case (size1_q)
            SIZE_LONG: bus_rdata_o <= {rd_word[15:8], 8'h00,
                                       rd_word[7:0], 8'h00};
            SIZE_WORD: bus_rdata_o <= {16'h0000, rd_word[15:8],
                                       8'h00};
            default: begin
              bus_rdata_o[15:8] <= is_low_byte(addr1_q)
                                   ? temp_q
                                   : rd_word[15:8];
            end
          endcase
        end else if (addr1_q == CTRL_STATUS_ADDR) begin
          bus_rdata_o[7:0] <= status_val;
        end else if (addr1_q == TRIG_SCAN_ADDR) begin
          bus_rdata_o[7:0] <= trig_val;
        end
      end
    end
  end

endmodule : adc_sequencer_control

// >>> verilog/result_store.sv
// four 16-bit result words, one write port, registered read port.
// assumes writer and reader share clk_i.
`timescale 1ns/100ps
module result_store (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // write side
  input  wire logic        wr_en_i,
  input  wire logic [1:0]  wr_idx_i,
  input  wire logic [15:0] wr_data_i,
  // read side
  input  wire logic [1:0]  rd_idx_i,
  output logic      [15:0] rd_data_o
);

  logic [15:0] mem_q [4];

  // storage, cleared at reset
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 4; i++) begin
        mem_q[i] <= 16'h0000;
      end
    end else if (wr_en_i) begin
      mem_q[wr_idx_i] <= wr_data_i;
    end
  end

  // registered read data
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rd_data_o <= 16'h0000;
    end else begin
      rd_data_o <= mem_q[rd_idx_i];
    end
  end

endmodule : result_store

// >>> verilog/sar_core.sv
// behavioural successive-approximation core: start/done handshake.
// assumes analog_i already synchronised to clk_i.
`timescale 1ns/100ps
module sar_core
  import adc_seq_pkg::*;
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  // control
  input  wire logic                start_i,
  input  wire logic                abort_i,
  input  wire logic [1:0]          chan_i,
  input  wire logic [CNT_W-1:0]    cycles_i,
  input  wire adc_seq_pkg::analog_vec_t analog_i,
  // answer
  output logic                     done_o,
  output logic [RES_BITS-1:0]      result_o
);

  logic [CNT_W-1:0]    cnt_q;
  logic [RES_BITS-1:0] sample_q;
  logic [RES_BITS-1:0] trial;
  logic [CNT_W-1:0]    bit_idx;

  // trial value for the bit decided this cycle
  always_comb begin
    bit_idx = cnt_q - CNT_W'(1);
    trial   = result_o | (RES_BITS'(1) << bit_idx);
  end

  // countdown, sample, one bit per state in the last states
  always_ff @(posedge clk_i) begin
    if (!resetn_i || abort_i) begin
      cnt_q    <= '0;
      sample_q <= '0;
      result_o <= '0;
      done_o   <= 1'b0;
    end else if (start_i) begin
      cnt_q    <= cycles_i;
      sample_q <= analog_i[chan_i*RES_BITS +: RES_BITS];
      result_o <= '0;
      done_o   <= 1'b0;
    end else begin
      done_o <= (cnt_q == CNT_W'(1));
      if (cnt_q != '0) begin
        cnt_q <= cnt_q - CNT_W'(1);
        if (cnt_q <= CNT_W'(RES_BITS) && trial <= sample_q) begin
          result_o <= trial;
        end
      end
    end
  end

endmodule : sar_core
